// ===== core/erc_pkg.sv
// erc_pkg: shared constants, opcode patterns and types of the instruction core.
// assumes 16-bit instruction words and the usual 8-bit status register layout.
package erc_pkg;

  // status register bit positions
  localparam int unsigned FLAG_C = 0;
  localparam int unsigned FLAG_Z = 1;
  localparam int unsigned FLAG_N = 2;
  localparam int unsigned FLAG_V = 3;
  localparam int unsigned FLAG_S = 4;
  localparam int unsigned FLAG_H = 5;
  localparam int unsigned FLAG_T = 6;
  localparam int unsigned FLAG_I = 7;

  // flag groups written by each instruction class
  localparam logic [7:0] MASK_ARITH = 8'h2F;
  localparam logic [7:0] MASK_LOGIC = 8'h0E;
  localparam logic [7:0] MASK_ROT = 8'h0F;
  localparam logic [7:0] MASK_PAIR = 8'h1F;

  // values after reset
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [16:0] HOLD_RESET = 17'h00000;

  // two-word instruction detection
  localparam logic [15:0] LONG_LDST_MASK = 16'hFC0F;
  localparam logic [15:0] LONG_LDST_CODE = 16'h9000;
  localparam logic [15:0] LONG_JMP_MASK = 16'hFE0C;
  localparam logic [15:0] LONG_JMP_CODE = 16'h940C;

  // register pair base and bit-accessible i/o limit
  localparam logic [1:0] PAIR_BASE = 2'h3;
  localparam logic [4:0] IO_BIT_LAST = 5'h1F;

  // opcode patterns
  localparam logic [15:0] OPC_ADD_ADC = 16'b000?_11??_????_????;
  localparam logic [15:0] OPC_SUB_SBC = 16'b000?_10??_????_????;
  localparam logic [15:0] OPC_CP_CPC = 16'b000?_01??_????_????;
  localparam logic [15:0] OPC_EQ_SKIP = 16'b0001_00??_????_????;
  localparam logic [15:0] OPC_LOGIC = 16'b0010_????_????_????;
  localparam logic [15:0] OPC_CMP_IMM = 16'b0011_????_????_????;
  localparam logic [15:0] OPC_DIFF_IMM = 16'b010?_????_????_????;
  localparam logic [15:0] OPC_LOGIC_IMM = 16'b011?_????_????_????;
  localparam logic [15:0] OPC_LOAD_IMM = 16'b1110_????_????_????;
  localparam logic [15:0] OPC_ROT_RIGHT = 16'b1001_010?_????_0111;
  localparam logic [15:0] OPC_PTR_JUMP = 16'b1001_010?_0000_1001;
  localparam logic [15:0] OPC_PAIR_IMM = 16'b1001_011?_????_????;
  localparam logic [15:0] OPC_IO_BIT = 16'b1001_10?0_????_????;
  localparam logic [15:0] OPC_IO_SKIP = 16'b1001_10?1_????_????;
  localparam logic [15:0] OPC_REL_JUMP = 16'b110?_????_????_????;
  localparam logic [15:0] OPC_FLAG_BRANCH = 16'b1111_0???_????_????;
  localparam logic [15:0] OPC_REG_SKIP = 16'b1111_11??_????_0???;

  typedef enum logic [2:0] {
    ALU_ADD = 3'h0,
    ALU_SUB = 3'h1,
    ALU_AND = 3'h2,
    ALU_XOR = 3'h3,
    ALU_OR = 3'h4,
    ALU_ROR = 3'h5
  } erc_alu_op_t;

  typedef enum logic [1:0] {
    ST_EXEC = 2'b00,
    ST_SECOND = 2'b01,
    ST_THIRD = 2'b11
  } erc_state_t;

  typedef enum logic [2:0] {
    JOB_WAIT = 3'h0,
    JOB_PAIR = 3'h1,
    JOB_IO = 3'h2,
    JOB_CALL = 3'h3,
    JOB_SKIP = 3'h4
  } erc_job_t;

endpackage

// ===== core/erc_alu_if.sv
// erc_alu_if: operands, carry and zero inputs, result and flags of the byte alu.
// assumes one driver module (core) and one computing module (alu).
`timescale 1ns/100ps
interface erc_alu_if;
  import erc_pkg::*;
  erc_alu_op_t op;
  logic [7:0] a;
  logic [7:0] b;
  logic cin;
  logic zin;
  logic [7:0] res;
  logic c;
  logic h;
  logic v;
  logic n;
  logic z;
  modport core(output op, a, b, cin, zin, input res, c, h, v, n, z);
  modport alu(input op, a, b, cin, zin, output res, c, h, v, n, z);
endinterface

// ===== core/erc_alu.sv
// erc_alu: combinational byte alu for add, subtract, logic and rotate.
// assumes the core gates which flags it keeps; zin chains zero for the subtract and compare carry forms.
`timescale 1ns/100ps
module erc_alu
  import erc_pkg::*;
(
  erc_alu_if.alu bus
);
  logic [7:0] a;
  logic [7:0] b;
  logic [7:0] r;

  always_comb begin
    a = bus.a;
    b = bus.b;
    r = 8'h00;
    bus.c = 1'b0;
    bus.h = 1'b0;
    bus.v = 1'b0;
    unique case (bus.op)
      ALU_ADD: begin
        r = a + b + {7'h00, bus.cin};
        bus.h = (a[3] & b[3]) | (b[3] & ~r[3]) | (~r[3] & a[3]);
        bus.c = (a[7] & b[7]) | (b[7] & ~r[7]) | (~r[7] & a[7]);
        bus.v = (a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]);
      end
      ALU_SUB: begin
        r = a - b - {7'h00, bus.cin};
        bus.h = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
        bus.c = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
        bus.v = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
      end
      ALU_AND: r = a & b;
      ALU_XOR: r = a ^ b;
      ALU_OR: r = a | b;
      ALU_ROR: begin
        r = {bus.cin, a[7:1]};
        bus.c = a[0];
        bus.v = r[7] ^ a[0];
      end
      default: r = a;
    endcase
    bus.res = r;
    bus.n = r[7];
    bus.z = (r == 8'h00) & bus.zin;
  end
endmodule

// ===== core/erc_core.sv
// erc_core: fetch, decode and execute of the arithmetic, logic, branch, skip and i/o bit group.
// assumes program memory and register file read combinationally on the same clock,
// the i/o space honours a per-bit write mask, and an outside stack takes pushed bytes.
`timescale 1ns/100ps
module erc_core
  import erc_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic ARST_N,
  // program memory
  output logic [15:0] PM_ADDR,
  input wire logic [15:0] PM_DATA,
  // register file
  output logic [4:0] RF_A_ADDR,
  input wire logic [7:0] RF_A_DATA,
  output logic [4:0] RF_B_ADDR,
  input wire logic [7:0] RF_B_DATA,
  output logic RF_WE,
  output logic [4:0] RF_W_ADDR,
  output logic [7:0] RF_W_DATA,
  input wire logic [15:0] Z_PTR,
  // i/o space
  output logic [4:0] IO_ADDR,
  input wire logic [7:0] IO_RD_DATA,
  output logic IO_WE,
  output logic [7:0] IO_WR_DATA,
  output logic [7:0] IO_WR_MASK,
  // return address push
  output logic PUSH_EN,
  output logic [7:0] PUSH_DATA,
  // status
  output logic [7:0] STATUS_FLAGS
);

  erc_alu_if alu_bus();

  erc_alu u_alu (
    .bus(alu_bus.alu)
  );

  erc_state_t state;
  erc_state_t next_state;
  erc_job_t job;
  erc_job_t next_job;
  logic [15:0] pc;
  logic [15:0] next_pc;
  logic [7:0] status_flags_register;
  logic [7:0] next_status_flags_register;
  logic [4:0] hold_addr;
  logic [4:0] next_hold_addr;
  logic [16:0] hold_word;
  logic [16:0] next_hold_word;
  logic [7:0] hold_flags;
  logic [7:0] next_hold_flags;

  logic [15:0] inst;
  logic [4:0] dst;
  logic [4:0] src;
  logic [4:0] dst_hi;
  logic [7:0] imm;
  logic [7:0] flag_mask;
  logic [7:0] flag_new;
  logic [15:0] pair_word;
  logic [15:0] pair_res;
  logic [5:0] pair_imm;
  logic [7:0] pair_flags;
  logic flag_sel;
  logic is_long;

  assign inst = PM_DATA;
  assign dst = inst[8:4];
  assign src = {inst[9], inst[3:0]};
  assign dst_hi = {1'b1, inst[7:4]};
  assign imm = {inst[11:8], inst[3:0]};
  assign pair_imm = {inst[7:6], inst[3:0]};
  assign pair_word = {RF_B_DATA, RF_A_DATA};
  assign PM_ADDR = pc;
  assign STATUS_FLAGS = status_flags_register;

  // two-word instruction seen at the skipped slot
  assign is_long = ((inst & LONG_LDST_MASK) == LONG_LDST_CODE) ||
                   ((inst & LONG_JMP_MASK) == LONG_JMP_CODE);

  // pair arithmetic across the sixteen-bit register pair
  always_comb begin
    pair_flags = 8'h00;
    if (inst[8]) begin
      pair_res = pair_word - {10'h000, pair_imm};
      pair_flags[FLAG_V] = pair_word[15] & ~pair_res[15];
      pair_flags[FLAG_C] = pair_res[15] & ~pair_word[15];
    end else begin
      pair_res = pair_word + {10'h000, pair_imm};
      pair_flags[FLAG_V] = ~pair_word[15] & pair_res[15];
      pair_flags[FLAG_C] = ~pair_res[15] & pair_word[15];
    end
    pair_flags[FLAG_N] = pair_res[15];
    pair_flags[FLAG_Z] = (pair_res == 16'h0000);
    pair_flags[FLAG_S] = pair_flags[FLAG_N] ^ pair_flags[FLAG_V];
  end

  // branch condition: the signed-test position is decided from N and V directly
  always_comb begin
    if (inst[2:0] == FLAG_S[2:0]) begin
      flag_sel = status_flags_register[FLAG_N] ^ status_flags_register[FLAG_V];
    end else begin
      flag_sel = status_flags_register[inst[2:0]];
    end
  end

  always_comb begin
    next_state = state;
    next_job = job;
    next_pc = pc;
    next_hold_addr = hold_addr;
    next_hold_word = hold_word;
    next_hold_flags = hold_flags;
    alu_bus.op = ALU_ADD;
    alu_bus.a = RF_A_DATA;
    alu_bus.b = RF_B_DATA;
    alu_bus.cin = 1'b0;
    alu_bus.zin = 1'b1;
    RF_A_ADDR = dst;
    RF_B_ADDR = src;
    RF_WE = 1'b0;
    RF_W_ADDR = dst;
    RF_W_DATA = alu_bus.res;
    IO_ADDR = inst[7:3];
    IO_WE = 1'b0;
    IO_WR_DATA = 8'h00;
    IO_WR_MASK = 8'h00;
    PUSH_EN = 1'b0;
    PUSH_DATA = 8'h00;
    flag_mask = 8'h00;
    flag_new = {2'b00, alu_bus.h, alu_bus.n ^ alu_bus.v, alu_bus.v, alu_bus.n, alu_bus.z, alu_bus.c};
    unique case (state)
      ST_EXEC: begin
        next_pc = pc + 16'h0001;
        casez (inst)
          OPC_ADD_ADC: begin
            alu_bus.cin = inst[12] & status_flags_register[FLAG_C];
            RF_WE = 1'b1;
            flag_mask = MASK_ARITH;
          end
          OPC_SUB_SBC: begin
            alu_bus.op = ALU_SUB;
            alu_bus.cin = ~inst[12] & status_flags_register[FLAG_C];
            alu_bus.zin = inst[12] | status_flags_register[FLAG_Z];
            RF_WE = 1'b1;
            flag_mask = MASK_ARITH;
          end
          OPC_CP_CPC: begin
            alu_bus.op = ALU_SUB;
            alu_bus.cin = ~inst[12] & status_flags_register[FLAG_C];
            alu_bus.zin = inst[12] | status_flags_register[FLAG_Z];
            flag_mask = MASK_ARITH;
          end
          OPC_CMP_IMM: begin
            RF_A_ADDR = dst_hi;
            alu_bus.op = ALU_SUB;
            alu_bus.b = imm;
            flag_mask = MASK_ARITH;
          end
          OPC_DIFF_IMM: begin
            RF_A_ADDR = dst_hi;
            RF_W_ADDR = dst_hi;
            alu_bus.op = ALU_SUB;
            alu_bus.b = imm;
            alu_bus.cin = ~inst[12] & status_flags_register[FLAG_C];
            alu_bus.zin = inst[12] | status_flags_register[FLAG_Z];
            RF_WE = 1'b1;
            flag_mask = MASK_ARITH;
          end
          OPC_LOGIC: begin
            unique case (inst[11:10])
              2'b00: alu_bus.op = ALU_AND;
              2'b01: alu_bus.op = ALU_XOR;
              default: alu_bus.op = ALU_OR;
            endcase
            RF_WE = (inst[11:10] != 2'b11);
            flag_mask = (inst[11:10] != 2'b11) ? MASK_LOGIC : 8'h00;
          end
          OPC_LOGIC_IMM: begin
            RF_A_ADDR = dst_hi;
            RF_W_ADDR = dst_hi;
            alu_bus.op = inst[12] ? ALU_AND : ALU_OR;
            alu_bus.b = imm;
            RF_WE = 1'b1;
            flag_mask = MASK_LOGIC;
          end
          OPC_LOAD_IMM: begin
            RF_W_ADDR = dst_hi;
            RF_W_DATA = imm;
            RF_WE = 1'b1;
          end
          OPC_PTR_JUMP: begin
            next_pc = Z_PTR;
            next_hold_word = {1'b0, pc + 16'h0001};
            next_job = inst[8] ? JOB_CALL : JOB_WAIT;
            next_state = ST_SECOND;
          end
          OPC_ROT_RIGHT: begin
            alu_bus.op = ALU_ROR;
            alu_bus.cin = status_flags_register[FLAG_C];
            RF_WE = 1'b1;
            flag_mask = MASK_ROT;
          end
          OPC_PAIR_IMM: begin
            RF_A_ADDR = {PAIR_BASE, inst[5:4], 1'b0};
            RF_B_ADDR = {PAIR_BASE, inst[5:4], 1'b1};
            RF_W_ADDR = {PAIR_BASE, inst[5:4], 1'b0};
            RF_W_DATA = pair_res[7:0];
            RF_WE = 1'b1;
            next_hold_addr = {PAIR_BASE, inst[5:4], 1'b1};
            next_hold_word = {9'h000, pair_res[15:8]};
            next_hold_flags = pair_flags;
            next_job = JOB_PAIR;
            next_state = ST_SECOND;
          end
          OPC_IO_BIT: begin
            next_hold_addr = inst[7:3] & IO_BIT_LAST;
            next_hold_word = {8'h00, inst[9], 8'h01 << inst[2:0]};
            next_job = JOB_IO;
            next_state = ST_SECOND;
          end
          OPC_IO_SKIP: begin
            if (IO_RD_DATA[inst[2:0]] == inst[9]) begin
              next_job = JOB_SKIP;
              next_state = ST_SECOND;
            end
          end
          OPC_EQ_SKIP: begin
            if (RF_A_DATA == RF_B_DATA) begin
              next_job = JOB_SKIP;
              next_state = ST_SECOND;
            end
          end
          OPC_REG_SKIP: begin
            RF_A_ADDR = dst;
            if (RF_A_DATA[inst[2:0]] == inst[9]) begin
              next_job = JOB_SKIP;
              next_state = ST_SECOND;
            end
          end
          OPC_REL_JUMP: begin
            next_pc = pc + 16'h0001 + {{4{inst[11]}}, inst[11:0]};
            next_hold_word = {1'b0, pc + 16'h0001};
            next_job = inst[12] ? JOB_CALL : JOB_WAIT;
            next_state = ST_SECOND;
          end
          OPC_FLAG_BRANCH: begin
            if (flag_sel != inst[10]) begin
              next_pc = pc + 16'h0001 + {{9{inst[9]}}, inst[9:3]};
              next_job = JOB_WAIT;
              next_state = ST_SECOND;
            end
          end
          default: begin
          end
        endcase
      end
      ST_SECOND: begin
        next_state = ST_EXEC;
        unique case (job)
          JOB_PAIR: begin
            RF_W_ADDR = hold_addr;
            RF_W_DATA = hold_word[7:0];
            RF_WE = 1'b1;
            flag_new = hold_flags;
            flag_mask = MASK_PAIR;
          end
          JOB_IO: begin
            IO_ADDR = hold_addr;
            IO_WE = 1'b1;
            IO_WR_MASK = hold_word[7:0];
            IO_WR_DATA = hold_word[8] ? hold_word[7:0] : 8'h00;
          end
          JOB_CALL: begin
            PUSH_EN = 1'b1;
            PUSH_DATA = hold_word[7:0];
            next_state = ST_THIRD;
          end
          JOB_SKIP: begin
            if (is_long) begin
              next_pc = pc + 16'h0002;
              next_state = ST_THIRD;
            end else begin
              next_pc = pc + 16'h0001;
            end
          end
          default: begin
          end
        endcase
      end
      ST_THIRD: begin
        next_state = ST_EXEC;
        if (job == JOB_CALL) begin
          PUSH_EN = 1'b1;
          PUSH_DATA = hold_word[15:8];
        end
      end
      default: next_state = ST_EXEC;
    endcase
    next_status_flags_register = (status_flags_register & ~flag_mask) | (flag_new & flag_mask);
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state <= ST_EXEC;
      job <= JOB_WAIT;
      pc <= PC_RESET;
      status_flags_register <= STATUS_RESET;
      hold_addr <= 5'h00;
      hold_word <= HOLD_RESET;
      hold_flags <= STATUS_RESET;
    end else begin
      state <= next_state;
      job <= next_job;
      pc <= next_pc;
      status_flags_register <= next_status_flags_register;
      hold_addr <= next_hold_addr;
      hold_word <= next_hold_word;
      hold_flags <= next_hold_flags;
    end
  end

endmodule

// ===== test/erc_core_properties.sv
// erc_core_properties: port-level timing and value relations of the core.
// assumes one clock domain; bound onto every erc_core instance.
`timescale 1ns/100ps
module erc_core_properties (
  // clock and reset
  input wire logic CLK,
  input wire logic ARST_N,
  // instruction and register file
  input wire logic [15:0] PM_ADDR,
  input wire logic [15:0] PM_DATA,
  input wire logic [7:0] RF_A_DATA,
  input wire logic [7:0] RF_B_DATA,
  input wire logic RF_WE,
  input wire logic [4:0] RF_W_ADDR,
  input wire logic [7:0] RF_W_DATA,
  // i/o, push and status
  input wire logic [4:0] IO_ADDR,
  input wire logic IO_WE,
  input wire logic [7:0] IO_WR_DATA,
  input wire logic [7:0] IO_WR_MASK,
  input wire logic PUSH_EN,
  input wire logic [7:0] PUSH_DATA,
  input wire logic [7:0] STATUS_FLAGS
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  logic own;
  assign own = RF_WE && RF_W_ADDR == {PM_DATA[8], PM_DATA[7:4]};
  chk_io_we_pulse: assert property (IO_WE |=> !IO_WE)
    else $error("i/o write strobe longer than one cycle");
  chk_io_target: assert property (IO_WE |-> IO_ADDR == $past(PM_DATA[7:3])
    && IO_WR_MASK == 8'h01 << $past(PM_DATA[2:0]))
    else $error("i/o bit write address or mask wrong");
  chk_io_data: assert property (IO_WE |-> IO_WR_DATA == ($past(PM_DATA[9]) ? IO_WR_MASK : 8'h00))
    else $error("i/o bit write data wrong");
  chk_push_pair: assert property (PUSH_EN && !$past(PUSH_EN) |=> PUSH_EN ##1 !PUSH_EN)
    else $error("call did not push exactly two bytes");
  chk_push_low: assert property (PUSH_EN && !$past(PUSH_EN) |-> PUSH_DATA == 8'($past(PM_ADDR) + 16'h0001))
    else $error("return address low byte wrong");
  chk_push_high: assert property (PUSH_EN && $past(PUSH_EN)
    |-> PUSH_DATA == 8'(($past(PM_ADDR, 2) + 16'h0001) >> 8))
    else $error("return address high byte wrong");
  chk_jump_idle: assert property (PM_ADDR != $past(PM_ADDR) + 16'h0001 && PM_ADDR != $past(PM_ADDR)
    |=> $stable(PM_ADDR))
    else $error("no idle cycle after a change of flow");
  chk_add_sum: assert property (own && PM_DATA[15:10] == 6'b000011
    |-> RF_W_DATA == 8'(RF_A_DATA + RF_B_DATA))
    else $error("register add result wrong");
  chk_logic_flags: assert property (own && PM_DATA[15:12] == 4'h2
    |=> !STATUS_FLAGS[3] && $stable(STATUS_FLAGS[5:4]) && $stable(STATUS_FLAGS[0])
    && STATUS_FLAGS[2] == $past(RF_W_DATA[7]) && STATUS_FLAGS[1] == ($past(RF_W_DATA) == 8'h00))
    else $error("logic operation flags wrong");
  chk_load_flags: assert property (RF_WE && PM_DATA[15:12] == 4'hE && RF_W_ADDR == {1'b1, PM_DATA[7:4]}
    && RF_W_DATA == {PM_DATA[11:8], PM_DATA[3:0]} |=> $stable(STATUS_FLAGS))
    else $error("immediate load changed flags");
  chk_it_fixed: assert property ($stable(STATUS_FLAGS[7:6]))
    else $error("interrupt or transfer bit changed");
  cover property (IO_WE);
  cover property (PUSH_EN ##1 PUSH_EN);
  cover property (own && PM_DATA[15:10] == 6'b000011);
endmodule

bind erc_core erc_core_properties u_props (
  .CLK(CLK), .ARST_N(ARST_N), .PM_ADDR(PM_ADDR), .PM_DATA(PM_DATA),
  .RF_A_DATA(RF_A_DATA), .RF_B_DATA(RF_B_DATA), .RF_WE(RF_WE),
  .RF_W_ADDR(RF_W_ADDR), .RF_W_DATA(RF_W_DATA), .IO_ADDR(IO_ADDR), .IO_WE(IO_WE),
  .IO_WR_DATA(IO_WR_DATA), .IO_WR_MASK(IO_WR_MASK), .PUSH_EN(PUSH_EN),
  .PUSH_DATA(PUSH_DATA), .STATUS_FLAGS(STATUS_FLAGS)
);

// ===== test/erc_mem_model.sv
// erc_mem_model: program memory, register file, i/o space and push capture.
// assumes combinational reads and writes at the rising clock edge.
`timescale 1ns/100ps
module erc_mem_model (
  // clock
  input wire logic clk,
  // program memory
  input wire logic [15:0] pm_addr,
  output logic [15:0] pm_data,
  // register file
  input wire logic [4:0] ra,
  output logic [7:0] rda,
  input wire logic [4:0] rb,
  output logic [7:0] rdb,
  input wire logic we,
  input wire logic [4:0] wa,
  input wire logic [7:0] wd,
  output logic [15:0] z,
  // i/o space and stack
  input wire logic [4:0] io_addr,
  output logic [7:0] io_rd,
  input wire logic io_we,
  input wire logic [7:0] io_wd,
  input wire logic [7:0] io_wm,
  input wire logic push_en,
  input wire logic [7:0] push_data
);
  logic [15:0] pm [256];
  logic [7:0] rf [32];
  logic [7:0] io [32];
  logic [7:0] pushed [$];
  assign pm_data = pm[pm_addr[7:0]];
  assign rda = rf[ra];
  assign rdb = rf[rb];
  assign z = {rf[31], rf[30]};
  assign io_rd = io[io_addr];
  always @(posedge clk) begin
    if (we) rf[wa] <= wd;
    if (io_we) io[io_addr] <= (io[io_addr] & ~io_wm) | (io_wd & io_wm);
    if (push_en) pushed.push_back(push_data);
  end
endmodule

// ===== test/tb.sv
// tb: self-checking bench for erc_core, random arithmetic plus directed flow.
// assumes erc_mem_model stands for program memory, registers and i/o.
`timescale 1ns/100ps
module tb;
  import erc_pkg::*;
  logic CLK = 1'b0;
  logic ARST_N = 1'b0;
  logic [15:0] pa, pd, zp;
  logic [4:0] ra, rb, wa, ia;
  logic [7:0] rda, rdb, wd, ird, iwd, iwm, pdat, flags;
  logic we, iwe, pen;
  int n_errors = 0;
  int checks = 0;
  logic [31:0] seed = 32'h2B98A0C4;
  logic [7:0] ca [4] = '{8'h80, 8'h0F, 8'h55, 8'h7F};
  logic [7:0] cb [4] = '{8'h01, 8'h01, 8'h55, 8'hFF};
  logic [15:0] iop [16] = '{16'h9AF9, 16'h98F8, 16'h9BF9, 16'hE101, 16'h99F8, 16'h940C, 16'hE443, 16'hE212,
    16'h1311, 16'hE323, 16'hFD10, 16'hE545, 16'hFF15, 16'hE656, 16'h9BF8, 16'hE767};
  int skp [5] = '{16, 19, 18, 20, 21};
  int fa [13] = '{0, 1, 2, 8, 9, 10, 11, 12, 13, 20, 21, 22, 24};
  logic [15:0] fw [13] = '{16'hE0E8, 16'h9409, 16'hE001, 16'hD002, 16'hE019, 16'hE019, 16'hE1E4,
    16'h9509, 16'hE929, 16'hE727, 16'hC002, 16'hE131, 16'hE54A};
  logic [7:0] pex [4] = '{8'h09, 8'h00, 8'h0D, 8'h00};
  always #2 CLK = ~CLK;
  erc_core dut (
    .CLK(CLK), .ARST_N(ARST_N), .PM_ADDR(pa), .PM_DATA(pd), .RF_A_ADDR(ra), .RF_A_DATA(rda),
    .RF_B_ADDR(rb), .RF_B_DATA(rdb), .RF_WE(we), .RF_W_ADDR(wa), .RF_W_DATA(wd), .Z_PTR(zp),
    .IO_ADDR(ia), .IO_RD_DATA(ird), .IO_WE(iwe), .IO_WR_DATA(iwd), .IO_WR_MASK(iwm),
    .PUSH_EN(pen), .PUSH_DATA(pdat), .STATUS_FLAGS(flags));
  erc_mem_model mdl (
    .clk(CLK), .pm_addr(pa), .pm_data(pd), .ra(ra), .rda(rda), .rb(rb), .rdb(rdb), .we(we),
    .wa(wa), .wd(wd), .z(zp), .io_addr(ia), .io_rd(ird), .io_we(iwe), .io_wd(iwd),
    .io_wm(iwm), .push_en(pen), .push_data(pdat));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] ik(logic [3:0] o, logic [3:0] d, logic [7:0] k);
    return {o, k[7:4], d, k[3:0]};
  endfunction
  // result and flags after reset-cleared flags
  function automatic logic [15:0] exp_op(int m, logic [7:0] a, logic [7:0] b);
    logic [8:0] r;
    logic [7:0] f;
    logic s;
    s = (m >= 1 && m <= 3);
    r = s ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
    case (m)
      4: r = {1'b0, a ^ b};
      5: r = {1'b0, a & b};
      6: r = {1'b0, a | b};
      7: r = {1'b0, a & (8'hFF - b)};
      8: r = {2'b00, a[7:1]};
      default: ;
    endcase
    f = 8'h00;
    f[1] = (r[7:0] == 8'h00);
    f[2] = r[7];
    if (m < 4) begin
      f[0] = r[8];
      f[3] = s ? (a[7] ^ b[7]) & (a[7] ^ r[7]) : ~(a[7] ^ b[7]) & (a[7] ^ r[7]);
      f[5] = s ? (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]) : (a[3] & b[3]) | (b[3] & ~r[3]) | (~r[3] & a[3]);
    end
    if (m == 8) begin
      f[0] = a[0];
      f[3] = r[7] ^ a[0];
    end
    if (m == 2) r = {1'b0, a};
    return {r[7:0], f};
  endfunction
  function automatic logic [23:0] pair_exp(logic [15:0] w, logic [5:0] k, logic sb);
    logic [16:0] r;
    logic [7:0] f;
    r = sb ? {1'b0, w} - k : {1'b0, w} + k;
    f = {3'b000, 1'b0, ~w[15] & r[15], r[15], r[15:0] == 16'h0000, r[16]};
    if (sb) f[3] = w[15] & ~r[15];
    f[4] = f[2] ^ f[3];
    return {r[15:0], f};
  endfunction
  task automatic chk(logic [31:0] seen, logic [31:0] want);
    checks++;
    if (seen !== want) begin
      n_errors++;
      $display("mismatch at %0t seen %0h expected %0h", $time, seen, want);
    end
  endtask
  task automatic boot();
    ARST_N = 1'b0;
    mdl.pushed.delete();
    for (int i = 0; i < 256; i++) begin
      mdl.pm[i] = 16'h0000;
      mdl.rf[i % 32] = 8'h00;
      mdl.io[i % 32] = 8'h00;
    end
  endtask
  task automatic run(int n);
    repeat (6) @(posedge CLK);
    #1 ARST_N = 1'b1;
    repeat (n) @(posedge CLK);
    #1;
  endtask
  task automatic t_random();
    logic [7:0] a, b;
    logic [15:0] e, w;
    logic fv;
    int m, s, st;
    for (int i = 0; i < 72; i++) begin
      a = (i < 4) ? ca[i] : 8'(rnd());
      b = (i < 4) ? cb[i] : 8'(rnd());
      m = i % 9;
      s = (i / 9) % 8;
      st = (i / 2) % 2;
      case (m)
        0: w = 16'h0F01;
        1: w = 16'h1B01;
        2: w = 16'h1701;
        3: w = ik(4'h5, 4'h0, b);
        4: w = 16'h2701;
        5: w = ik(4'h7, 4'h0, b);
        6: w = ik(4'h6, 4'h0, b);
        7: w = ik(4'h7, 4'h0, ~b);
        default: w = 16'h9507;
      endcase
      e = exp_op(m, a, b);
      fv = (s == 4) ? e[FLAG_N] ^ e[FLAG_V] : e[s];
      boot();
      mdl.pm[0] = ik(4'hE, 4'h0, a);
      mdl.pm[1] = ik(4'hE, 4'h1, b);
      mdl.pm[2] = w;
      mdl.pm[3] = ik(4'hE, 4'h4, 8'hFF);
      mdl.pm[4] = (st == 1 ? 16'hF008 : 16'hF408) | 16'(s);
      mdl.pm[5] = ik(4'hE, 4'h2, 8'h01);
      mdl.pm[6] = ik(4'hE, 4'h3, 8'h02);
      run(12);
      chk(mdl.rf[16], e[15:8]);
      chk(flags, e[7:0]);
      chk(mdl.rf[20], 8'hFF);
      chk(mdl.rf[18], (fv == st) ? 8'h00 : 8'h01);
      chk(mdl.rf[19], 8'h02);
    end
    $display("random test done");
  endtask
  task automatic t_pair();
    logic [15:0] wv;
    logic [5:0] k;
    logic [23:0] e;
    for (int j = 0; j < 6; j++) begin
      wv = (j == 0) ? 16'hFFFF : (j == 1) ? 16'h0000 : 16'(rnd());
      k = (j < 2) ? 6'h01 : 6'(rnd());
      e = pair_exp(wv, k, j[0]);
      boot();
      mdl.pm[0] = ik(4'hE, 4'h8, wv[7:0]);
      mdl.pm[1] = ik(4'hE, 4'h9, wv[15:8]);
      mdl.pm[2] = {7'b1001011, j[0], k[5:4], 2'b00, k[3:0]};
      run(8);
      chk({mdl.rf[25], mdl.rf[24]}, e[23:8]);
      chk(flags, e[7:0]);
    end
    $display("pair test done");
  endtask
  task automatic t_io();
    boot();
    foreach (iop[q]) mdl.pm[q] = iop[q];
    mdl.io[31] = 8'hA5;
    run(40);
    chk(mdl.io[31], (8'hA5 | 8'h02) & 8'hFE);
    foreach (skp[q]) chk(mdl.rf[skp[q]], 8'h00);
    chk(mdl.rf[17], 8'h22);
    chk(mdl.rf[22], 8'h77);
    $display("i/o and skip test done");
  endtask
  task automatic t_flow();
    boot();
    foreach (fa[q]) mdl.pm[fa[q]] = fw[q];
    run(30);
    foreach (skp[q]) chk(mdl.rf[skp[q]], skp[q] == 18 ? 8'h77 : skp[q] == 20 ? 8'h5A : 8'h00);
    chk(mdl.rf[17], 8'h00);
    chk(mdl.pushed.size(), 4);
    foreach (pex[q]) chk(mdl.pushed[q], pex[q]);
    $display("flow test done");
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    t_random();
    t_pair();
    t_io();
    t_flow();
    report_and_stop();
  end
  initial begin
    #20000;
    n_errors++;
    report_and_stop();
  end
endmodule
